// ==== fos_consts.vh ====
// Purpose: Constants for the flash command sequencer (once-program, erase, unsecure).
// Assumes: Included by fos_seq.v, by its assertion module and by the bench.
// Notes: Offsets are word indices on the plain register port.
`ifndef FOS_CONSTS_VH
`define FOS_CONSTS_VH
// ==========================================
// Register offsets
`define FOS_A_STAT 4'h0
`define FOS_A_IDX 4'h1
`define FOS_A_DATA 4'h2
`define FOS_A_PROT 4'h3
`define FOS_A_MODE 4'h4
`define FOS_A_SEC 4'h5
`define FOS_A_OTPST 4'h6
// ==========================================
// Status field positions
`define FOS_B_CCF 7
`define FOS_B_ACC 5
`define FOS_B_PV 4
`define FOS_B_VE1 1
`define FOS_B_VE0 0
// Protection register bit positions
`define FOS_B_PPROT 0
`define FOS_B_DPROT 1
`define FOS_B_SECTP 2
// Mode register: bit 0 allows erase-all, bit 1 allows the rest
`define FOS_B_MALL 0
`define FOS_B_MNRM 1
// ==========================================
// Command codes
`define FOS_C_ONCE 8'h07
`define FOS_C_ALL 8'h08
`define FOS_C_BLK 8'h09
`define FOS_C_SECT 8'h0a
`define FOS_C_UNSEC 8'h0b
// Parameter indices
`define FOS_I_000 3'h0
`define FOS_I_001 3'h1
`define FOS_I_101 3'h5
`define FOS_ONCE_MAX 16'h0007
// Valid blocks: addr[22:16]
`define FOS_BLK_P0 7'h7f
`define FOS_BLK_D0 7'h10
// ==========================================
// Reset values
`define FOS_R_MODE 2'h3
`define FOS_R_PROT 3'h0
// Array operation times
`define FOS_T_PROG_US 20
`define FOS_T_ERASE_US 200
`define FOS_CLK_MHZ 20
`endif

// ==== fos_seq.v ====
// Purpose: Flash command sequencer for once-program, block/sector/all erase, unsecure.
// Assumes: Single clock; array behaviour modelled by timers and verify-fail and verify-uncorrectable inputs.
// Notes: Register port has one-cycle read latency and never stalls.
`timescale 1ns/100ps
`include "fos_consts.vh"

// What this block does
// - Once-program writes only 8 phrases of reserved field in block 0.
// - Once-program checks erased, programs, verifies; complete flag clear meanwhile.
// - Phrase index above 0x0007 raises access error.
// - Reprogramming an already programmed phrase raises access error.
// - Phrase programmed to all ones still counts as unprogrammed.
// - Reads of block 0 return invalid data during once-program.
// - Last parameter index must match command or access error.
// - Command not permitted in current mode raises access error.
// - Verify failures set verify-error bit 1; uncorrectable also set bit 0.
// - Code 0x08 erases all flash, verifies, releases security on success.
// - Erase-all and unsecure raise protection violation if P-flash or D-flash is protected.
// - Code 0x09 erases block named by address bits 22..16 and 15..0.
// - Block and sector erase reject invalid block bits with access error.
// - Block erase rejects misaligned P-flash or D-flash addresses.
// - Block erase raises protection violation if block protected.
// - Code 0x0A erases sector containing address, then verifies.
// - Sector erase: address low bits nonzero is access error; protected sector violates.
// - Code 0x0B erases, verifies, unsecures; failure sets bit 1, security unchanged.
// - Clearing complete flag launches; flag sets when operation fully finishes.
module fos_seq (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire verify_fail,
  input wire verify_uncorr,
  input wire blk0_rd,
  output reg [15:0] reg_rdata,
  output reg blk0_rd_invalid,
  output reg array_busy,
  output reg secure_q
);
  localparam PROG_CYC = `FOS_T_PROG_US * `FOS_CLK_MHZ;
  localparam ERASE_CYC = `FOS_T_ERASE_US * `FOS_CLK_MHZ;
  // ==========================================
  // States, one-hot
  localparam S_IDLE = 4'b0001;
  localparam S_CHK = 4'b0010;
  localparam S_OPER = 4'b0100;
  localparam S_VER = 4'b1000;

  reg [3:0] state_q;
  reg [15:0] cmd_param_array [0:5];
  reg [2:0] param_index;
  reg cmd_complete_flag;
  reg access_error_flag;
  reg protect_violation_flag;
  reg verify_error_any;
  reg verify_error_uncorrectable;
  reg [2:0] prot_q;
  reg [1:0] mode_q;
  reg [7:0] once_done_q;
  reg [15:0] timer_q;
  reg unsec_q;
  integer i;

  wire [7:0] cmd = cmd_param_array[0][15:8];
  wire [6:0] blk = cmd_param_array[0][6:0];
  wire [15:0] addr_lo = cmd_param_array[1];
  wire [2:0] phr = cmd_param_array[1][2:0];
  wire data_all_ones = &{cmd_param_array[2], cmd_param_array[3], cmd_param_array[4],
    cmd_param_array[5]};

  function blk_ok;
    input [6:0] b;
    begin
      blk_ok = (b == `FOS_BLK_P0) || (b == `FOS_BLK_D0);
    end
  endfunction

  function [15:0] cyc16;
    input integer n;
    begin
      cyc16 = n[15:0];
    end
  endfunction

  // ==========================================
  // Launch checks
  reg acc_err;
  reg pv_err;
  always @* begin
    acc_err = 1'b0;
    pv_err = 1'b0;
    case (cmd)
      `FOS_C_ONCE: begin
        acc_err = (param_index != `FOS_I_101) || !mode_q[`FOS_B_MNRM] ||
          (addr_lo > `FOS_ONCE_MAX) ||
          once_done_q[phr];
      end
      `FOS_C_ALL, `FOS_C_UNSEC: begin
        acc_err = (param_index != `FOS_I_000) ||
          !mode_q[(cmd == `FOS_C_ALL) ? `FOS_B_MALL : `FOS_B_MNRM];
        pv_err = prot_q[`FOS_B_PPROT] | prot_q[`FOS_B_DPROT];
      end
      `FOS_C_BLK: begin
        acc_err = (param_index != `FOS_I_001) || !mode_q[`FOS_B_MNRM] ||
          !blk_ok(blk) ||
          ((blk == `FOS_BLK_P0) ? (addr_lo[2:0] != 3'h0) : addr_lo[0]);
        pv_err = (blk == `FOS_BLK_P0) ? prot_q[`FOS_B_PPROT] : prot_q[`FOS_B_DPROT];
      end
      `FOS_C_SECT: begin
        acc_err = (param_index != `FOS_I_001) || !mode_q[`FOS_B_MNRM] ||
          (blk != `FOS_BLK_P0) ||
          (addr_lo[2:0] != 3'h0);
        pv_err = prot_q[`FOS_B_SECTP];
      end
      default: acc_err = 1'b1;
    endcase
  end

  // ==========================================
  // Sequencer and registers
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      for (i = 0; i < 6; i = i + 1) begin
        cmd_param_array[i] <= 16'h0000;
      end
      param_index <= 3'h0;
      cmd_complete_flag <= 1'b1;
      access_error_flag <= 1'b0;
      protect_violation_flag <= 1'b0;
      verify_error_any <= 1'b0;
      verify_error_uncorrectable <= 1'b0;
      prot_q <= `FOS_R_PROT;
      mode_q <= `FOS_R_MODE;
      once_done_q <= 8'h00;
      timer_q <= 16'h0000;
      unsec_q <= 1'b0;
      reg_rdata <= 16'h0000;
      blk0_rd_invalid <= 1'b0;
      array_busy <= 1'b0;
      secure_q <= 1'b1;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `FOS_A_STAT: reg_rdata <= {8'h00, cmd_complete_flag, 1'b0, access_error_flag,
            protect_violation_flag, 2'b00, verify_error_any, verify_error_uncorrectable};
          `FOS_A_IDX: reg_rdata <= {13'h0000, param_index};
          `FOS_A_DATA: reg_rdata <= (param_index < 3'h6) ? cmd_param_array[param_index]
            : 16'h0000;
          `FOS_A_PROT: reg_rdata <= {13'h0000, prot_q};
          `FOS_A_MODE: reg_rdata <= {14'h0000, mode_q};
          `FOS_A_SEC: reg_rdata <= {15'h0000, secure_q};
          `FOS_A_OTPST: reg_rdata <= {8'h00, once_done_q};
          default: reg_rdata <= 16'h0000;
        endcase
      end
      // Writes are ignored while busy; protects a running erase
      if (reg_wr && cmd_complete_flag) begin
        case (reg_addr)
          `FOS_A_STAT: begin
            if (reg_wdata[`FOS_B_ACC]) access_error_flag <= 1'b0;
            if (reg_wdata[`FOS_B_PV]) protect_violation_flag <= 1'b0;
            // Launch refused while old access or protection errors stand
            if (reg_wdata[`FOS_B_CCF] && !access_error_flag && !protect_violation_flag)
              begin
              cmd_complete_flag <= 1'b0;
              verify_error_any <= 1'b0;
              verify_error_uncorrectable <= 1'b0;
              state_q <= S_CHK;
            end
          end
          `FOS_A_IDX: param_index <= reg_wdata[2:0];
          `FOS_A_DATA: if (param_index < 3'h6) cmd_param_array[param_index] <= reg_wdata;
          `FOS_A_PROT: prot_q <= reg_wdata[2:0];
          `FOS_A_MODE: mode_q <= reg_wdata[1:0];
          default: ;
        endcase
      end
      blk0_rd_invalid <= blk0_rd && array_busy && (cmd == `FOS_C_ONCE);
      case (state_q)
        S_IDLE: ;
        S_CHK: begin
          if (acc_err || pv_err) begin
            access_error_flag <= acc_err;
            protect_violation_flag <= pv_err;
            cmd_complete_flag <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            array_busy <= 1'b1;
            unsec_q <= (cmd == `FOS_C_ALL) || (cmd == `FOS_C_UNSEC);
            timer_q <= (cmd == `FOS_C_ONCE) ? cyc16(PROG_CYC) : cyc16(ERASE_CYC);
            state_q <= S_OPER;
          end
        end
        S_OPER: begin
          if (timer_q != 16'h0000) begin
            timer_q <= timer_q - 16'h0001;
          end else begin
            state_q <= S_VER;
          end
        end
        S_VER: begin
          array_busy <= 1'b0;
          if (verify_fail) begin
            verify_error_any <= 1'b1;
            verify_error_uncorrectable <= verify_uncorr;
          end else if (unsec_q) begin
            secure_q <= 1'b0;
          end
          // Only the 8 reserved phrases are tracked; all-ones stays open
          if (cmd == `FOS_C_ONCE && !data_all_ones) once_done_q[phr] <= 1'b1;
          cmd_complete_flag <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // fos_seq

// ==== fos_seq_sva.sv ====
// Purpose: Port checks for fos_seq.
// Assumes: clk_en held high while checked.
// Notes: Bound to every fos_seq at the foot.
`timescale 1ns/100ps
`include "fos_consts.vh"
module fos_seq_sva (
  input wire sys_clk,
  input wire rst_b,
  input wire clk_en,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire verify_fail,
  input wire verify_uncorr,
  input wire blk0_rd,
  input wire [15:0] reg_rdata,
  input wire blk0_rd_invalid,
  input wire array_busy,
  input wire secure_q
);
  // ==========================================
  // Helpers and checks
  reg [12:0] busy_q;
  reg [2:0] since_q;
  wire launch = reg_wr && reg_addr == `FOS_A_STAT && reg_wdata[`FOS_B_CCF];
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 13'h0;
      since_q <= 3'h7;
    end else begin
      busy_q <= array_busy ? busy_q + 13'h1 : 13'h0;
      since_q <= launch ? 3'h0 : since_q + {2'h0, since_q != 3'h7};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_start; $rose(array_busy); endsequence
  sequence s_hold; array_busy [*8]; endsequence
  property p_hold; s_start |-> s_hold; endproperty
  a_hold: assert property (p_hold) else $error("busy too short");
  property p_len; $fell(array_busy) |-> busy_q >= 13'h18e && busy_q <= 13'hfa4; endproperty
  a_len: assert property (p_len) else $error("busy length off");
  property p_start; s_start |-> since_q <= 3'h4; endproperty
  a_start: assert property (p_start) else $error("busy without launch");
  property p_inv; blk0_rd_invalid |-> $past(blk0_rd); endproperty
  a_inv: assert property (p_inv) else $error("invalid without read");
  property p_inv_busy; blk0_rd_invalid |-> array_busy || $past(array_busy); endproperty
  a_inv_busy: assert property (p_inv_busy) else $error("invalid while idle");
  property p_sec_up; !$past(secure_q) |-> !secure_q; endproperty
  a_sec_up: assert property (p_sec_up) else $error("security raised");
  property p_sec_vf; $fell(secure_q) |-> !$past(verify_fail); endproperty
  a_sec_vf: assert property (p_sec_vf) else $error("unsecured on failed verify");
  property p_sec_end; $fell(secure_q) |-> $past(array_busy) && !array_busy; endproperty
  a_sec_end: assert property (p_sec_end) else $error("unsecured outside erase end");
endmodule // fos_seq_sva
bind fos_seq fos_seq_sva u_sva (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .verify_fail(verify_fail), .verify_uncorr(verify_uncorr), .blk0_rd(blk0_rd),
  .reg_rdata(reg_rdata), .blk0_rd_invalid(blk0_rd_invalid), .array_busy(array_busy),
  .secure_q(secure_q));

// ==== test_flash_once_erase_unsecure_cmds.sv ====
// Purpose: Self-checking bench for fos_seq.
// Assumes: 20 MHz clock, clk_en held high.
// Notes: Reads are checked against a queue of expected words.
`timescale 1ns/100ps
`include "fos_consts.vh"
module test_flash_once_erase_unsecure_cmds;
  // ==========================================
  // Stimulus and checking
  reg sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0;
  reg verify_fail = 1'b0, verify_uncorr = 1'b0, blk0_rd = 1'b1, rd_d = 1'b0, ones = 1'b0;
  reg [2:0] pr = 3'h0;
  reg [1:0] md = 2'h3, vfu = 2'h0;
  wire [15:0] reg_rdata;
  wire blk0_rd_invalid, array_busy, secure_q;
  reg [31:0] seed = 32'h11b83cc7;
  int num_errors = 0;
  int n_tests = 0;
  logic [15:0] exp_q[$];
  always #25 sys_clk = ~sys_clk;
  fos_seq u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .verify_fail(verify_fail),
    .verify_uncorr(verify_uncorr), .blk0_rd(blk0_rd), .reg_rdata(reg_rdata),
    .blk0_rd_invalid(blk0_rd_invalid), .array_busy(array_busy), .secure_q(secure_q));
  task chk(input [15:0] got, input [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) rd_d <= reg_rd;
  always @(negedge sys_clk) if (rd_d) chk(reg_rdata, exp_q.pop_front());
  task bus(input w, input [3:0] a, input [15:0] d);
    @(posedge sys_clk);
    if (!w) exp_q.push_back(d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task rst;
    rst_b <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask
  task run(input [15:0] w0, input [15:0] lo, input [2:0] last, input [7:0] st, input sec);
    int i;
    bus(1, `FOS_A_PROT, {13'h0, pr});
    bus(1, `FOS_A_MODE, {14'h0, md});
    verify_fail <= vfu[1];
    verify_uncorr <= vfu[0];
    bus(1, `FOS_A_IDX, 16'h0);
    bus(1, `FOS_A_DATA, w0);
    bus(1, `FOS_A_IDX, 16'h1);
    bus(1, `FOS_A_DATA, lo);
    for (i = 2; i < 6; i++) begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      bus(1, `FOS_A_IDX, i[15:0]);
      bus(1, `FOS_A_DATA, ones ? 16'hffff : seed[15:0]);
    end
    // Random block-0 read level, held from here until the next run sets it again
    blk0_rd <= seed[7];
    bus(1, `FOS_A_IDX, {13'h0, last});
    bus(1, `FOS_A_STAT, 16'h0080);
    // No register writes until the complete flag is back
    for (i = 0; i < 5000 && (i < 4 || array_busy); i++) begin
      @(posedge sys_clk);
      if (i == 20) chk({15'h0, blk0_rd_invalid}, {15'h0, (w0[15:8] == `FOS_C_ONCE) && blk0_rd});
    end
    if (i == 5000) begin
      num_errors++;
      finish_test;
    end
    bus(0, `FOS_A_STAT, {8'h0, st});
    chk({15'h0, secure_q}, {15'h0, sec});
    bus(1, `FOS_A_STAT, 16'h0030);
    {pr, md, vfu, ones} = {3'h0, 2'h3, 2'h0, 1'b0};
  endtask
  initial begin
    rst;
    run(16'h0700, 16'h0008, 3'h5, 8'ha0, 1'b1);
    run(16'h0700, 16'h0003, 3'h1, 8'ha0, 1'b1);
    ones = 1'b1;
    run(16'h0700, 16'h0003, 3'h5, 8'h80, 1'b1);
    run(16'h0700, 16'h0003, 3'h5, 8'h80, 1'b1);
    run(16'h0700, 16'h0003, 3'h5, 8'ha0, 1'b1);
    bus(0, `FOS_A_OTPST, 16'h0008);
    vfu = 2'h3;
    run(16'h097f, 16'h0000, 3'h1, 8'h83, 1'b1);
    run(16'h0912, 16'h0000, 3'h1, 8'ha0, 1'b1);
    run(16'h097f, 16'h0004, 3'h1, 8'ha0, 1'b1);
    run(16'h0910, 16'h0001, 3'h1, 8'ha0, 1'b1);
    pr = 3'h1;
    run(16'h097f, 16'h0000, 3'h1, 8'h90, 1'b1);
    md = 2'h1;
    run(16'h097f, 16'h0000, 3'h1, 8'ha0, 1'b1);
    run(16'h0a7f, 16'h1238, 3'h1, 8'h80, 1'b1);
    run(16'h0a7f, 16'h1233, 3'h1, 8'ha0, 1'b1);
    pr = 3'h4;
    run(16'h0a7f, 16'h1238, 3'h1, 8'h90, 1'b1);
    pr = 3'h2;
    run(16'h0800, 16'h0000, 3'h0, 8'h90, 1'b1);
    md = 2'h2;
    run(16'h0800, 16'h0000, 3'h0, 8'ha0, 1'b1);
    run(16'h0b00, 16'h0000, 3'h1, 8'ha0, 1'b1);
    vfu = 2'h2;
    run(16'h0b00, 16'h0000, 3'h0, 8'h82, 1'b1);
    run(16'h0b00, 16'h0000, 3'h0, 8'h80, 1'b0);
    rst;
    run(16'h0800, 16'h0000, 3'h0, 8'h80, 1'b0);
    run(16'h0c00, 16'h0000, 3'h0, 8'ha0, 1'b0);
    bus(0, 4'hf, 16'h0000);
    repeat (2) @(posedge sys_clk);
    finish_test;
  end
endmodule // test_flash_once_erase_unsecure_cmds
